// ==== src/timer_pkg.sv ====
// Shared constants and types of the 16-bit timer/event counter
package timer_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  OFS_COUNT_HIGH  = 8'h0f;
    localparam logic [7:0]  OFS_COUNT_LOW   = 8'h10;
    localparam logic [7:0]  OFS_CONTROL     = 8'h11;
    localparam logic [7:0]  OFS_INT_STATUS  = 8'h12;
    localparam logic [7:0]  OFS_INT_CLEAR   = 8'h13;
    localparam logic [7:0]  OFS_INT_ENABLE  = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int unsigned CTL_EDGE_BIT    = 3;
    localparam int unsigned CTL_ON_BIT      = 4;
    localparam int unsigned CTL_MODE_LSB    = 6;
    localparam int unsigned OVF_BIT         = 6;
    localparam logic [7:0]  CTL_RESET       = 8'h08;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_MAX       = 16'hffff;
    localparam int unsigned COUNT_W         = 16;
    localparam int unsigned CLK_DIV         = 4;
    localparam int unsigned CLK_HZ          = 40_000_000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_UNUSED = 2'h0,
        MODE_EVENT  = 2'h1,
        MODE_TIMER  = 2'h2,
        MODE_PULSE  = 2'h3
    } mode_e;

    typedef enum logic [1:0] {
        PW_WAIT     = 2'h0,
        PW_MEASURE  = 2'h1
    } pw_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;

    typedef struct packed {
        mode_e mode;
        logic  count_on;
        logic  active_edge_sel;
    } ctl_s;

    typedef struct packed {
        ctl_s         ctl;
        logic [15:0]  preload;
        logic [15:0]  count;
        logic [7:0]   low_buf;
        logic [7:0]   rdata;
        logic         overflow_flag;
        logic         overflow_int_enable;
        pw_state_e    pw;
    } timer_state_s;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
    } sync_state_s;

endpackage

// ==== src/pin_edge_sync.sv ====
// Two-flop synchroniser with rise and fall detection for the timer input pin
module pin_edge_sync (
    // Clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_I,
    // Pin in, edges out
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    timer_pkg::sync_state_s st_reg;
    timer_pkg::sync_state_s st_next;

    // First flop feeds only the second; edges look at the settled copy
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin_i;
        st_next.sync2 = st_reg.sync1;
        st_next.prev  = st_reg.sync2;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.sync2;
    assign rise_o  = st_reg.sync2 & ~st_reg.prev;
    assign fall_o  = ~st_reg.sync2 & st_reg.prev;
endmodule

// ==== src/clk_div_tick.sv ====
// Free-running prescaler giving one tick every DIV system clocks
module clk_div_tick #(
    parameter int unsigned DIV = timer_pkg::CLK_DIV
) (
    // Clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_I,
    // Tick out
    output logic      tick_o
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + W'(1);
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick_o = (cnt_reg == LAST);
endmodule

// ==== src/timer_event_counter.sv ====
// 16-bit count-up timer/event counter with preload, byte latching and overflow interrupt
module timer_event_counter #(
    parameter int unsigned DIV = timer_pkg::CLK_DIV
) (
    // Clock and reset
    input  wire logic                          CLK_I,
    input  wire logic                          RST_I,
    // Register port
    input  wire logic [timer_pkg::ADDR_W-1:0]  ADDR_I,
    input  wire logic [7:0]                    WDATA_I,
    input  wire logic                          WR_I,
    input  wire logic                          RD_I,
    output logic      [7:0]                    RDATA_O,
    // Timer input pin
    input  wire logic                          TIMER_INPUT_PIN_I,
    // Interrupt and wake-up
    output logic                               IRQ_O,
    output logic                               WAKE_O
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic sel_edge(input logic rise, input logic fall, input logic falling);
        sel_edge = falling ? fall : rise;
    endfunction

    function automatic logic hit(input timer_pkg::bus_req_s r, input logic strobe,
                                 input logic [7:0] ofs);
        hit = strobe && (r.addr == ofs);
    endfunction

    // ****************************************
    // Input conditioning
    // ****************************************
    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic div_tick;

    pin_edge_sync u_sync (
        .CLK_I   (CLK_I),
        .RST_I   (RST_I),
        .pin_i   (TIMER_INPUT_PIN_I),
        .level_o (pin_level),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    clk_div_tick #(.DIV(DIV)) u_div (
        .CLK_I  (CLK_I),
        .RST_I  (RST_I),
        .tick_o (div_tick)
    );

    // ****************************************
    // State
    // ****************************************
    timer_pkg::timer_state_s st_reg;
    timer_pkg::timer_state_s st_next;
    timer_pkg::bus_req_s     req;

    logic wr_high;
    logic wr_low;
    logic wr_ctl;
    logic rd_high;
    logic start_edge;
    logic end_edge;
    logic inc;
    logic wrap;

    assign req      = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign wr_high  = hit(req, req.wr, timer_pkg::OFS_COUNT_HIGH);
    assign wr_low   = hit(req, req.wr, timer_pkg::OFS_COUNT_LOW);
    assign wr_ctl   = hit(req, req.wr, timer_pkg::OFS_CONTROL);
    assign rd_high  = hit(req, req.rd, timer_pkg::OFS_COUNT_HIGH);

    assign start_edge = sel_edge(pin_rise, pin_fall, st_reg.ctl.active_edge_sel);
    assign end_edge   = sel_edge(pin_rise, pin_fall, ~st_reg.ctl.active_edge_sel);

    // Count source per mode; a high byte read steals the tick so the
    // latched pair stays coherent, at the price of a lost count
    always_comb begin
        inc = 1'b0;
        if (st_reg.ctl.count_on && !rd_high) begin
            case (st_reg.ctl.mode)
                timer_pkg::MODE_EVENT: inc = start_edge;
                timer_pkg::MODE_TIMER: inc = div_tick;
                timer_pkg::MODE_PULSE: inc = div_tick && (st_reg.pw == timer_pkg::PW_MEASURE)
                                             && !end_edge;
                default:               inc = 1'b0;
            endcase
        end
    end

    assign wrap = inc && (st_reg.count == timer_pkg::COUNT_MAX);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;

        // Counting and overflow reload
        if (wrap) begin
            st_next.count = st_reg.preload;
        end else if (inc) begin
            st_next.count = st_reg.count + timer_pkg::COUNT_W'(1);
        end

        // Pulse width sequencer: one measurement per enable
        case (st_reg.pw)
            timer_pkg::PW_WAIT: begin
                if (st_reg.ctl.mode == timer_pkg::MODE_PULSE && st_reg.ctl.count_on && start_edge) begin
                    st_next.pw = timer_pkg::PW_MEASURE;
                end
            end
            timer_pkg::PW_MEASURE: begin
                if (!st_reg.ctl.count_on || st_reg.ctl.mode != timer_pkg::MODE_PULSE) begin
                    st_next.pw = timer_pkg::PW_WAIT;
                end else if (end_edge) begin
                    st_next.pw           = timer_pkg::PW_WAIT;
                    st_next.ctl.count_on = 1'b0;
                end
            end
            default: st_next.pw = timer_pkg::PW_WAIT;
        endcase

        // Register writes; a software write of the control wins
        if (wr_low) begin
            st_next.low_buf = req.wdata;
        end
        if (wr_high) begin
            st_next.preload = {req.wdata, st_reg.low_buf};
            if (!st_reg.ctl.count_on) begin
                st_next.count = {req.wdata, st_reg.low_buf};
            end
        end
        if (wr_ctl) begin
            st_next.ctl.mode            = timer_pkg::mode_e'(req.wdata[timer_pkg::CTL_MODE_LSB +: 2]);
            st_next.ctl.count_on        = req.wdata[timer_pkg::CTL_ON_BIT];
            st_next.ctl.active_edge_sel = req.wdata[timer_pkg::CTL_EDGE_BIT];
        end
        if (hit(req, req.wr, timer_pkg::OFS_INT_ENABLE)) begin
            st_next.overflow_int_enable = req.wdata[timer_pkg::OVF_BIT];
        end
        if (hit(req, req.wr, timer_pkg::OFS_INT_CLEAR) && req.wdata[timer_pkg::OVF_BIT]) begin
            st_next.overflow_flag = 1'b0;
        end
        // Set after clear so a coinciding overflow is never lost
        if (wrap) begin
            st_next.overflow_flag = 1'b1;
        end

        // Read data, valid the cycle after the strobe only
        st_next.rdata = '0;
        if (req.rd) begin
            case (req.addr)
                timer_pkg::OFS_COUNT_HIGH: begin
                    st_next.rdata   = st_reg.count[15:8];
                    st_next.low_buf = st_reg.count[7:0];
                end
                timer_pkg::OFS_COUNT_LOW:  st_next.rdata = st_reg.low_buf;
                timer_pkg::OFS_CONTROL: begin
                    st_next.rdata = '0;
                    st_next.rdata[timer_pkg::CTL_MODE_LSB +: 2] = st_reg.ctl.mode;
                    st_next.rdata[timer_pkg::CTL_ON_BIT]        = st_reg.ctl.count_on;
                    st_next.rdata[timer_pkg::CTL_EDGE_BIT]      = st_reg.ctl.active_edge_sel;
                end
                timer_pkg::OFS_INT_STATUS: st_next.rdata[timer_pkg::OVF_BIT] = st_reg.overflow_flag;
                timer_pkg::OFS_INT_ENABLE: st_next.rdata[timer_pkg::OVF_BIT] = st_reg.overflow_int_enable;
                default:                   st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_reg                     <= '0;
            st_reg.ctl.mode            <= timer_pkg::mode_e'(timer_pkg::CTL_RESET[timer_pkg::CTL_MODE_LSB +: 2]);
            st_reg.ctl.count_on        <= timer_pkg::CTL_RESET[timer_pkg::CTL_ON_BIT];
            st_reg.ctl.active_edge_sel <= timer_pkg::CTL_RESET[timer_pkg::CTL_EDGE_BIT];
            st_reg.preload             <= timer_pkg::COUNT_RESET;
            st_reg.count               <= timer_pkg::COUNT_RESET;
            st_reg.pw                  <= timer_pkg::PW_WAIT;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign RDATA_O = st_reg.rdata;
    assign IRQ_O   = st_reg.overflow_flag & st_reg.overflow_int_enable;
    // Wake-up follows the flag regardless of the enable
    assign WAKE_O  = st_reg.overflow_flag;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    chk_low_write_only: assert property (wr_low |=> st_reg.preload == $past(st_reg.preload))
        else $error("low byte write changed preload");
    chk_high_write_pair: assert property (wr_high |=> st_reg.preload == {$past(WDATA_I), $past(st_reg.low_buf)})
        else $error("high byte write did not load preload pair");
    chk_high_read_latch: assert property (rd_high |=> RDATA_O == $past(st_reg.count[15:8])
                                          && st_reg.low_buf == $past(st_reg.count[7:0]))
        else $error("high byte read did not latch counter");
    chk_overflow_reload: assert property (wrap |=> st_reg.count == $past(st_reg.preload)
                                          && st_reg.overflow_flag && WAKE_O)
        else $error("overflow did not reload and flag");
    chk_off_no_count: assert property (!st_reg.ctl.count_on && !wr_high |=> st_reg.count == $past(st_reg.count))
        else $error("counter moved while off");
    chk_ton_kept: assert property (st_reg.ctl.mode != timer_pkg::MODE_PULSE && st_reg.ctl.count_on && !wr_ctl
                                   |=> st_reg.ctl.count_on)
        else $error("count-on cleared by hardware");
    chk_pulse_end_clear: assert property (st_reg.pw == timer_pkg::PW_MEASURE && st_reg.ctl.count_on
                                          && st_reg.ctl.mode == timer_pkg::MODE_PULSE && end_edge && !wr_ctl
                                          |=> !st_reg.ctl.count_on)
        else $error("pulse end did not clear count-on");
    chk_irq_masked: assert property (!st_reg.overflow_int_enable |-> !IRQ_O)
        else $error("interrupt raised while disabled");
    chk_read_block: assert property (rd_high |=> st_reg.count == $past(st_reg.count))
        else $error("counter moved during high byte read");
    chk_flag_sticky: assert property (st_reg.overflow_flag && !WR_I |=> st_reg.overflow_flag)
        else $error("overflow flag dropped without clear");
    chk_pulse_start: assert property (st_reg.pw == timer_pkg::PW_WAIT && st_reg.ctl.count_on
                                      && st_reg.ctl.mode == timer_pkg::MODE_PULSE && start_edge
                                      |=> st_reg.pw == timer_pkg::PW_MEASURE)
        else $error("pulse measurement did not start on edge");

    cov_overflow: cover property (wrap ##1 IRQ_O);
    cov_pulse_done: cover property (st_reg.pw == timer_pkg::PW_MEASURE ##[1:200] st_reg.pw == timer_pkg::PW_WAIT);
    cov_event_count: cover property (st_reg.ctl.mode == timer_pkg::MODE_EVENT && inc);

    // ****************************************
    // Register port checks
    // ****************************************
    chk_rdata_idle: assert property (
        !RD_I
        |=> RDATA_O == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_low_read: assert property (
        RD_I && ADDR_I == timer_pkg::OFS_COUNT_LOW
        |=> RDATA_O == $past(st_reg.low_buf))
        else $error("low byte read did not return buffer");
    chk_ctl_read_zero: assert property (
        RD_I && ADDR_I == timer_pkg::OFS_CONTROL
        |=> (RDATA_O & 8'h27) == 8'h00)
        else $error("unused control bits read nonzero");
    chk_low_buf_write: assert property (
        wr_low
        |=> st_reg.low_buf == $past(WDATA_I))
        else $error("low byte write missed buffer");
    chk_off_load: assert property (
        wr_high && !st_reg.ctl.count_on
        |=> st_reg.count == {$past(WDATA_I), $past(st_reg.low_buf)})
        else $error("preload write while off did not load counter");
    chk_on_keep_count: assert property (
        wr_high && st_reg.ctl.count_on && !inc
        |=> st_reg.count == $past(st_reg.count))
        else $error("preload write while on changed counter");
    chk_mode_write: assert property (
        wr_ctl
        |=> st_reg.ctl.mode == timer_pkg::mode_e'($past(WDATA_I[timer_pkg::CTL_MODE_LSB +: 2])))
        else $error("mode field not taken from control write");
    chk_reset_values: assert property (
        $past(RST_I)
        |-> !st_reg.ctl.count_on && !IRQ_O && !WAKE_O && st_reg.count == timer_pkg::COUNT_RESET)
        else $error("state not at reset values after reset");

    // ****************************************
    // Counting checks
    // ****************************************
    chk_event_edge: assert property (
        st_reg.ctl.count_on && st_reg.ctl.mode == timer_pkg::MODE_EVENT && start_edge && !rd_high
        |-> inc)
        else $error("selected edge not counted");
    chk_timer_tick: assert property (
        st_reg.ctl.count_on && st_reg.ctl.mode == timer_pkg::MODE_TIMER && !div_tick
        |-> !inc)
        else $error("timer counted without prescaler tick");
    chk_pulse_tick: assert property (
        st_reg.pw == timer_pkg::PW_MEASURE && st_reg.ctl.count_on && st_reg.ctl.mode == timer_pkg::MODE_PULSE
        && div_tick && !end_edge && !rd_high
        |-> inc)
        else $error("pulse measurement missed a tick");
    chk_pulse_hold: assert property (
        st_reg.ctl.mode == timer_pkg::MODE_PULSE && !st_reg.ctl.count_on && !wr_high
        |=> st_reg.count == $past(st_reg.count) && st_reg.pw == timer_pkg::PW_WAIT)
        else $error("pulse result not held");
    chk_edge_sync: assert property (
        pin_rise
        |-> $past(TIMER_INPUT_PIN_I, 2))
        else $error("rise seen without synchronised pin high");

    // ****************************************
    // Flag checks
    // ****************************************
    chk_irq_follows: assert property (
        st_reg.overflow_flag && st_reg.overflow_int_enable
        |-> IRQ_O)
        else $error("enabled flag did not raise interrupt");
    chk_clear_flag: assert property (
        hit(req, req.wr, timer_pkg::OFS_INT_CLEAR) && WDATA_I[timer_pkg::OVF_BIT] && !wrap
        |=> !st_reg.overflow_flag)
        else $error("flag clear ignored");

    cov_pulse_overflow: cover property (st_reg.pw == timer_pkg::PW_MEASURE && wrap);
    cov_read_block: cover property (rd_high && st_reg.ctl.count_on && div_tick
                                    && st_reg.ctl.mode == timer_pkg::MODE_TIMER);
endmodule

// ==== verif/pin_pulse_source.sv ====
// Behavioural source of pulses on the timer input pin
module pin_pulse_source (
    // Clock
    input  wire logic CLK_I,
    // Pin out
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin_o = 1'b0;

    // High for w clocks, then a low gap long enough for the synchroniser to settle
    task automatic pulse(input int unsigned w);
        @(posedge CLK_I);
        pin_o <= 1'b1;
        repeat (w) @(posedge CLK_I);
        pin_o <= 1'b0;
        repeat (6) @(posedge CLK_I);
    endtask
endmodule

// ==== verif/timer_event_counter_tb.sv ====
// Self-checking testbench of the 16-bit timer/event counter
module timer_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic       clk;
    logic       rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       pin;
    logic       irq;
    logic       wake;
    int         error_cnt = 0;
    int         samples_checked = 0;

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Short prescaler keeps the timed scenarios brief
    timer_event_counter #(.DIV(2)) uut (
        .CLK_I            (clk),
        .RST_I            (rst),
        .ADDR_I           (addr),
        .WDATA_I          (wdata),
        .WR_I             (wr),
        .RD_I             (rd),
        .RDATA_O          (rdata),
        .TIMER_INPUT_PIN_I(pin),
        .IRQ_O            (irq),
        .WAKE_O           (wake)
    );

    pin_pulse_source src (
        .CLK_I(clk),
        .pin_o(pin)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim;
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // High byte first so the low byte comes from the latched copy
    task automatic rd_cnt(output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        bus_rd(timer_pkg::OFS_COUNT_HIGH, h);
        bus_rd(timer_pkg::OFS_COUNT_LOW, l);
        v = {h, l};
    endtask

    task automatic load(input logic [15:0] v);
        bus_wr(timer_pkg::OFS_COUNT_LOW, v[7:0]);
        bus_wr(timer_pkg::OFS_COUNT_HIGH, v[15:8]);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_and_bytes;
        logic [7:0]  d;
        logic [15:0] v;
        bus_rd(timer_pkg::OFS_CONTROL, d);
        chk({8'h00, d}, {8'h00, timer_pkg::CTL_RESET});
        chk({14'h0000, irq, wake}, 16'h0000);
        bus_wr(timer_pkg::OFS_COUNT_LOW, 8'h34);
        bus_rd(timer_pkg::OFS_COUNT_LOW, d);
        chk({8'h00, d}, 16'h0034);
        bus_rd(timer_pkg::OFS_COUNT_HIGH, d);
        chk({8'h00, d}, 16'h0000);
        bus_rd(timer_pkg::OFS_COUNT_LOW, d);
        chk({8'h00, d}, 16'h0000);
        load(16'h1234);
        rd_cnt(v);
        chk(v, 16'h1234);
        bus_wr(8'h20, 8'hff);
        bus_rd(8'h20, d);
        chk({8'h00, d}, 16'h0000);
        bus_wr(timer_pkg::OFS_CONTROL, 8'h27);
        bus_rd(timer_pkg::OFS_CONTROL, d);
        chk({8'h00, d}, 16'h0000);
    endtask

    task automatic t_event_overflow;
        logic [7:0]  d;
        logic [15:0] v;
        load(16'hfffe);
        bus_wr(timer_pkg::OFS_CONTROL, 8'h50);
        src.pulse(4);
        rd_cnt(v);
        chk(v, 16'hffff);
        src.pulse(4);
        rd_cnt(v);
        chk(v, 16'hfffe);
        chk({15'h0000, wake}, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        bus_rd(timer_pkg::OFS_INT_STATUS, d);
        chk({8'h00, d}, 16'h0040);
        bus_rd(timer_pkg::OFS_CONTROL, d);
        chk({8'h00, d}, 16'h0050);
        bus_wr(timer_pkg::OFS_INT_ENABLE, 8'h40);
        #1 chk({15'h0000, irq}, 16'h0001);
        bus_wr(timer_pkg::OFS_INT_CLEAR, 8'h40);
        #1 chk({14'h0000, irq, wake}, 16'h0000);
        bus_wr(timer_pkg::OFS_CONTROL, 8'h40);
        src.pulse(4);
        rd_cnt(v);
        chk(v, 16'hfffe);
    endtask

    task automatic t_timer;
        logic [15:0] v;
        logic [15:0] v2;
        load(16'h0000);
        bus_wr(timer_pkg::OFS_CONTROL, 8'h90);
        repeat (40) @(posedge clk);
        rd_cnt(v);
        chk({15'h0000, v >= 16'd19 && v <= 16'd24}, 16'h0001);
        load(16'h0005);
        rd_cnt(v2);
        chk({15'h0000, v2 > v}, 16'h0001);
    endtask

    task automatic t_pulse;
        logic [7:0]  d;
        logic [15:0] v;
        logic [15:0] v2;
        bus_wr(timer_pkg::OFS_CONTROL, 8'hc0);
        load(16'h0000);
        bus_wr(timer_pkg::OFS_CONTROL, 8'hd0);
        repeat (10) @(posedge clk);
        rd_cnt(v);
        chk(v, 16'h0000);
        src.pulse(20);
        rd_cnt(v);
        chk({15'h0000, v >= 16'd9 && v <= 16'd11}, 16'h0001);
        bus_rd(timer_pkg::OFS_CONTROL, d);
        chk({8'h00, d}, 16'h00c0);
        src.pulse(20);
        rd_cnt(v2);
        chk(v2, v);
        bus_wr(timer_pkg::OFS_INT_CLEAR, 8'h40);
        load(16'hfff8);
        bus_wr(timer_pkg::OFS_CONTROL, 8'hd0);
        src.pulse(20);
        chk({15'h0000, wake}, 16'h0001);
    endtask

    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        rst   <= 1'b1;
        addr  <= 8'h00;
        wdata <= 8'h00;
        wr    <= 1'b0;
        rd    <= 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset_and_bytes();
        t_event_overflow();
        t_timer();
        t_pulse();
        end_sim();
    end

    // The scenarios need well under two thousand clocks
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule
